// ==== design/ivpm_pkg.sv ====
// shared constants and types for the interrupt vector priority map
package ivpm_pkg;

  // flag/mask bit positions
  localparam int unsigned BIT_EXT     = 0;
  localparam int unsigned BIT_WDOG    = 1;
  localparam int unsigned BIT_TIMER   = 3;
  localparam int unsigned BIT_P0_RX   = 4;
  localparam int unsigned BIT_P0_TX   = 5;
  localparam int unsigned BIT_SH58    = 6;
  localparam int unsigned BIT_SH5C    = 7;
  localparam int unsigned BIT_HOST    = 9;
  localparam int unsigned BIT_SH68    = 10;
  localparam int unsigned BIT_SH6C    = 11;
  localparam int unsigned BIT_DMA4    = 12;
  localparam int unsigned BIT_DMA5    = 13;
  localparam int unsigned FLAG_W      = 16;
  localparam int unsigned NUM_MASK    = 12;

  localparam logic [FLAG_W-1:0] FLAG_RST  = 16'h0000;
  localparam logic [FLAG_W-1:0] MASK_RST  = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAG_USED = 16'h3efb;

  // vector-relative locations
  localparam logic [6:0] VEC_RESET = 7'h00;
  localparam logic [6:0] VEC_NMI   = 7'h04;
  localparam logic [6:0] VEC_TRAP0 = 7'h08;
  localparam logic [6:0] VEC_EXT   = 7'h40;
  localparam logic [6:0] VEC_WDOG  = 7'h44;
  localparam logic [6:0] VEC_TIMER = 7'h4c;
  localparam logic [6:0] VEC_P0_RX = 7'h50;
  localparam logic [6:0] VEC_P0_TX = 7'h54;
  localparam logic [6:0] VEC_SH58  = 7'h58;
  localparam logic [6:0] VEC_SH5C  = 7'h5c;
  localparam logic [6:0] VEC_HOST  = 7'h64;
  localparam logic [6:0] VEC_SH68  = 7'h68;
  localparam logic [6:0] VEC_SH6C  = 7'h6c;
  localparam logic [6:0] VEC_DMA4  = 7'h70;
  localparam logic [6:0] VEC_DMA5  = 7'h74;

  // priorities
  localparam logic [4:0] PRI_RESET = 5'h01;
  localparam logic [4:0] PRI_NMI   = 5'h02;
  localparam logic [4:0] PRI_NONE  = 5'h00;

  // software traps
  localparam logic [4:0] TRAP_FIRST = 5'h11;
  localparam logic [4:0] TRAP_LAST  = 5'h1e;
  localparam logic [1:0] WORD_STEP  = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [6:0] vector;
    logic [4:0] priority_rank;
  } ivpm_vec_t;

  typedef struct packed {
    logic p0_rx;
    logic p0_tx;
    logic p1_rx;
    logic p1_tx;
    logic p2_rx;
    logic p2_tx;
  } ivpm_port_t;

  typedef struct packed {
    logic [5:0] ch;
  } ivpm_dma_t;

endpackage

// ==== design/ivpm_table.sv ====
// fixed table of maskable sources: bit index to vector and priority
`timescale 1ns/10ps
`default_nettype none
module ivpm_table (
  // lookup
  input  wire logic [3:0]         bit_i,
  output var ivpm_pkg::ivpm_vec_t entry_o
);

  always_comb begin
    entry_o = '{valid: 1'b1, vector: ivpm_pkg::VEC_RESET, priority_rank: ivpm_pkg::PRI_NONE};
    unique case (bit_i)
      4'h0: entry_o = '{1'b1, ivpm_pkg::VEC_EXT,   5'h03};
      4'h1: entry_o = '{1'b1, ivpm_pkg::VEC_WDOG,  5'h04};
      4'h3: entry_o = '{1'b1, ivpm_pkg::VEC_TIMER, 5'h06};
      4'h4: entry_o = '{1'b1, ivpm_pkg::VEC_P0_RX, 5'h07};
      4'h5: entry_o = '{1'b1, ivpm_pkg::VEC_P0_TX, 5'h08};
      4'h6: entry_o = '{1'b1, ivpm_pkg::VEC_SH58,  5'h09};
      4'h7: entry_o = '{1'b1, ivpm_pkg::VEC_SH5C,  5'h0a};
      4'h9: entry_o = '{1'b1, ivpm_pkg::VEC_HOST,  5'h0c};
      4'ha: entry_o = '{1'b1, ivpm_pkg::VEC_SH68,  5'h0d};
      4'hb: entry_o = '{1'b1, ivpm_pkg::VEC_SH6C,  5'h0e};
      4'hc: entry_o = '{1'b1, ivpm_pkg::VEC_DMA4,  5'h0f};
      4'hd: entry_o = '{1'b1, ivpm_pkg::VEC_DMA5,  5'h10};
      // reserved bits and 78..7f carry no source
      default: entry_o = '{1'b0, ivpm_pkg::VEC_RESET, ivpm_pkg::PRI_NONE};
    endcase
  end

endmodule
`default_nettype wire

// ==== design/ivpm_top.sv ====
// interrupt vector and priority selection for one subsystem
`timescale 1ns/10ps
`default_nettype none
module ivpm_top (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // request sources, one-cycle pulses
  input  wire logic                   reset_request_i,
  input  wire logic                   soft_reset_i,
  input  wire logic                   nmi_request_i,
  input  wire logic                   ext_request_i,
  input  wire logic                   watchdog_request_i,
  input  wire logic                   timer_request_i,
  input  wire logic                   host_to_core_bit_i,
  input  wire ivpm_pkg::ivpm_port_t   port_request_i,
  input  wire ivpm_pkg::ivpm_dma_t    dma_request_i,
  // shared slot routing, 1 selects the dma channel
  input  wire logic [3:0]             dma_select_i,
  // core access to flags and mask
  input  wire logic                   mask_we_i,
  input  wire logic [15:0]            mask_wdata_i,
  input  wire logic                   flag_clr_we_i,
  input  wire logic [15:0]            flag_clr_i,
  input  wire logic                   global_enable_i,
  // trap instruction
  input  wire logic                   trap_i,
  input  wire logic [4:0]             trap_num_i,
  // vector fetch handshake
  input  wire logic                   ack_i,
  output logic                        irq_o,
  output logic [6:0]                  vector_o,
  output logic [4:0]                  priority_o,
  output logic [15:0]                 pending_flags_o,
  output logic [15:0]                 enable_mask_o
);

  ////////////////////////////////////////////////////////////////////////
  // source mapping

  logic [15:0] raw_req;
  logic [15:0] pending_flags_r;
  logic [15:0] enable_mask_r;
  logic [15:0] active;
  logic        host_bit_q_r;
  logic        host_rise;

  assign host_rise = host_to_core_bit_i & ~host_bit_q_r;

  always_comb begin
    raw_req = 16'h0000;
    raw_req[ivpm_pkg::BIT_EXT]   = ext_request_i;
    raw_req[ivpm_pkg::BIT_WDOG]  = watchdog_request_i;
    raw_req[ivpm_pkg::BIT_TIMER] = timer_request_i;
    raw_req[ivpm_pkg::BIT_P0_RX] = port_request_i.p0_rx;
    raw_req[ivpm_pkg::BIT_P0_TX] = port_request_i.p0_tx;
    raw_req[ivpm_pkg::BIT_SH58]  = dma_select_i[0] ? dma_request_i.ch[0] : port_request_i.p2_rx;
    raw_req[ivpm_pkg::BIT_SH5C]  = dma_select_i[1] ? dma_request_i.ch[1] : port_request_i.p2_tx;
    raw_req[ivpm_pkg::BIT_HOST]  = host_rise;
    raw_req[ivpm_pkg::BIT_SH68]  = dma_select_i[2] ? dma_request_i.ch[2] : port_request_i.p1_rx;
    raw_req[ivpm_pkg::BIT_SH6C]  = dma_select_i[3] ? dma_request_i.ch[3] : port_request_i.p1_tx;
    raw_req[ivpm_pkg::BIT_DMA4]  = dma_request_i.ch[4];
    raw_req[ivpm_pkg::BIT_DMA5]  = dma_request_i.ch[5];
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      host_bit_q_r <= 1'b0;
    end else begin
      host_bit_q_r <= host_to_core_bit_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags and mask

  logic        take_mask;
  logic [15:0] take_clr;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_mask_r <= ivpm_pkg::MASK_RST;
    end else if (mask_we_i) begin
      enable_mask_r <= mask_wdata_i & ivpm_pkg::FLAG_USED;
    end
  end

  // set wins over any clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pending_flags_r <= ivpm_pkg::FLAG_RST;
    end else begin
      pending_flags_r <= ((pending_flags_r & ~take_clr) | raw_req) & ivpm_pkg::FLAG_USED;
    end
  end

  assign active = pending_flags_r & enable_mask_r;

  ////////////////////////////////////////////////////////////////////////
  // priority selection

  logic [3:0]          win_bit;
  logic                win_any;
  ivpm_pkg::ivpm_vec_t win_entry;

  // lowest bit index carries the smallest priority number
  always_comb begin
    win_bit = 4'h0;
    win_any = 1'b0;
    for (int i = ivpm_pkg::FLAG_W - 1; i >= 0; i--) begin
      if (active[i]) begin
        win_bit = 4'(i);
        win_any = 1'b1;
      end
    end
  end

  ivpm_table u_table (
    .bit_i   (win_bit),
    .entry_o (win_entry)
  );

  ////////////////////////////////////////////////////////////////////////
  // vector output

  logic                reset_pend_r;
  logic                nmi_pend_r;
  logic                trap_pend_r;
  logic [4:0]          trap_num_r;
  ivpm_pkg::ivpm_vec_t sel;
  logic                sel_mask;
  logic [6:0]          trap_vec;

  // four-word slots: trap offset shifted up by the slot step
  assign trap_vec = ivpm_pkg::VEC_TRAP0 + 7'({2'h0, 5'(trap_num_r - ivpm_pkg::TRAP_FIRST)} << ivpm_pkg::WORD_STEP);

  always_comb begin
    sel      = '{1'b0, ivpm_pkg::VEC_RESET, ivpm_pkg::PRI_NONE};
    sel_mask = 1'b0;
    if (reset_pend_r) begin
      sel = '{1'b1, ivpm_pkg::VEC_RESET, ivpm_pkg::PRI_RESET};
    end else if (nmi_pend_r) begin
      sel = '{1'b1, ivpm_pkg::VEC_NMI, ivpm_pkg::PRI_NMI};
    end else if (trap_pend_r) begin
      sel = '{1'b1, trap_vec, ivpm_pkg::PRI_NONE};
    end else if (global_enable_i && win_any && win_entry.valid) begin
      sel      = win_entry;
      sel_mask = 1'b1;
    end
  end

  assign take_mask = ack_i & sel_mask;
  assign take_clr  = (take_mask ? (16'h0001 << win_bit) : 16'h0000) | (flag_clr_we_i ? flag_clr_i : 16'h0000);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reset_pend_r <= 1'b1;
    end else if (reset_request_i || soft_reset_i) begin
      reset_pend_r <= 1'b1;
    end else if (ack_i) begin
      reset_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_request_i) begin
      nmi_pend_r <= 1'b1;
    end else if (ack_i && !reset_pend_r) begin
      nmi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      trap_pend_r <= 1'b0;
      trap_num_r  <= ivpm_pkg::TRAP_FIRST;
    end else if (trap_i && trap_num_i >= ivpm_pkg::TRAP_FIRST && trap_num_i <= ivpm_pkg::TRAP_LAST) begin
      trap_pend_r <= 1'b1;
      trap_num_r  <= trap_num_i;
    end else if (ack_i && !reset_pend_r && !nmi_pend_r) begin
      trap_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      vector_o   <= ivpm_pkg::VEC_RESET;
      priority_o <= ivpm_pkg::PRI_NONE;
    end else begin
      vector_o   <= sel.vector;
      priority_o <= sel.priority_rank;
    end
  end

  assign irq_o           = sel.valid;
  assign pending_flags_o = pending_flags_r;
  assign enable_mask_o   = enable_mask_r;

endmodule
`default_nettype wire

// ==== verification/ivpm_assertions.sv ====
// port-level checks for the interrupt vector priority map
`timescale 1ns/10ps
`default_nettype none
module ivpm_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  // requests and core controls
  input wire logic        reset_request_i,
  input wire logic        soft_reset_i,
  input wire logic        watchdog_request_i,
  input wire logic        timer_request_i,
  input wire logic        host_to_core_bit_i,
  input wire logic        mask_we_i,
  input wire logic [15:0] mask_wdata_i,
  input wire logic        global_enable_i,
  input wire logic        ack_i,
  // watched outputs
  input wire logic        irq_o,
  input wire logic [6:0]  vector_o,
  input wire logic [4:0]  priority_o,
  input wire logic [15:0] pending_flags_o,
  input wire logic [15:0] enable_mask_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  rst_vec_a: assert property (
    (reset_request_i || soft_reset_i) |=> irq_o ##1 (vector_o == 7'h00 && priority_o == 5'h01))
    else $error("reset request not shown at slot 00");
  rst_rel_a: assert property (
    $fell(reset_i) |-> ##2 (irq_o && vector_o == 7'h00 && priority_o == 5'h01))
    else $error("reset slot not shown after release");
  slot_map_a: assert property (
    (priority_o >= 5'h03) |-> (vector_o == {priority_o, 2'b00} + 7'h34))
    else $error("vector does not match priority");
  trap_map_a: assert property (
    (priority_o == 5'h00 && vector_o != 7'h00) |-> (vector_o inside {[7'h08:7'h3c]} && vector_o[1:0] == 2'h0))
    else $error("trap vector out of range");
  mask_wr_a: assert property (
    mask_we_i |=> (enable_mask_o == ($past(mask_wdata_i) & 16'h3efb)))
    else $error("mask write not kept");
  wdog_flag_a: assert property (
    watchdog_request_i |=> pending_flags_o[1])
    else $error("watchdog flag not set");
  host_flag_a: assert property (
    $rose(host_to_core_bit_i) |-> ##[1:2] pending_flags_o[9])
    else $error("host flag not set");
  ext_first_a: assert property (
    ($rose(irq_o) && global_enable_i && pending_flags_o[0] && enable_mask_o[0]) |=> (priority_o <= 5'h03))
    else $error("external request lost priority");
  ack_clr_a: assert property (
    (ack_i && irq_o && priority_o == 5'h06 && !timer_request_i) |=> !pending_flags_o[3])
    else $error("ack did not clear winner");
endmodule
`default_nettype wire

// ==== verification/ivpm_core_model.sv ====
// cpu core stand-in: takes a shown request after a set delay
`timescale 1ns/10ps
`default_nettype none
module ivpm_core_model (
  // clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       en_i,
  input  wire logic [1:0] lat_i,
  // vector fetch
  input  wire logic       irq_i,
  output logic            ack_o = 1'b0
);
  logic [1:0] cnt_r = 2'h0;
  // acks stay up while requests keep coming, like a busy core
  always @(posedge sys_clk_i) begin
    ack_o <= irq_i && en_i && (cnt_r >= lat_i);
    if (!(irq_i && en_i)) begin
      cnt_r <= 2'h0;
    end else if (cnt_r != 2'h3) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_interrupt_vector_priority_map.sv ====
// self-checking bench for the interrupt vector priority map
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_vector_priority_map;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 rst_req, soft_rst, nmi, ext, wdog, tmr, host, trap, mask_we, clr_we, gen, en, ack, irq;
  logic [1:0]           lat;
  logic [3:0]           sel;
  logic [4:0]           trap_n, pri;
  logic [6:0]           vec;
  logic [15:0]          mask_wd, clr_d, flags, mask;
  ivpm_pkg::ivpm_port_t port;
  ivpm_pkg::ivpm_dma_t  dma;
  int                   bad_count = 0;
  int                   n_tests = 0;
  int                   cyc = 0;
  always #20 clk = ~clk;
  ivpm_top u_dut (.sys_clk_i(clk), .reset_i(rst), .reset_request_i(rst_req), .soft_reset_i(soft_rst),
    .nmi_request_i(nmi), .ext_request_i(ext), .watchdog_request_i(wdog), .timer_request_i(tmr),
    .host_to_core_bit_i(host), .port_request_i(port), .dma_request_i(dma), .dma_select_i(sel),
    .mask_we_i(mask_we), .mask_wdata_i(mask_wd), .flag_clr_we_i(clr_we), .flag_clr_i(clr_d),
    .global_enable_i(gen), .trap_i(trap), .trap_num_i(trap_n), .ack_i(ack), .irq_o(irq),
    .vector_o(vec), .priority_o(pri), .pending_flags_o(flags), .enable_mask_o(mask));
  ivpm_core_model u_core (.sys_clk_i(clk), .en_i(en), .lat_i(lat), .irq_i(irq), .ack_o(ack));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic clr();
    {rst_req, soft_rst, nmi, ext, wdog, tmr, host, trap, mask_we, clr_we} = '0;
    port = '0;
    dma = '0;
  endtask
  task automatic drive(input int k);
    sel = (k >= 10 && k <= 13) ? 4'hf : 4'h0;
    case (k)
      0: ext = 1'b1;
      1: wdog = 1'b1;
      2: tmr = 1'b1;
      3: port.p0_rx = 1'b1;
      4: port.p0_tx = 1'b1;
      5: port.p2_rx = 1'b1;
      6: port.p2_tx = 1'b1;
      7: host = 1'b1;
      8: port.p1_rx = 1'b1;
      9: port.p1_tx = 1'b1;
      16: nmi = 1'b1;
      17: rst_req = 1'b1;
      18: soft_rst = 1'b1;
      default: dma.ch[k-10] = 1'b1;
    endcase
  endtask
  // request sampled at the first rising edge after entry
  task automatic expect_irq(input logic [6:0] v, input logic [4:0] p, input logic [15:0] f, input bit last);
    @(negedge clk);
    clr();
    chk("irq", 16'h1, 16'(irq));
    chk("flags", f, flags);
    @(negedge clk);
    chk("vector", 16'(v), 16'(vec));
    chk("priority", 16'(p), 16'(pri));
    if (last) begin
      @(negedge clk);
      chk("idle", 16'h0, 16'(irq));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (3) @(negedge clk);
    chk("rst irq", 16'h1, 16'(irq));
    chk("rst vec", 16'h0, 16'(vec));
    chk("rst pri", 16'h1, 16'(pri));
    chk("rst flags", 16'h0, flags);
    chk("rst mask", 16'h0, mask);
    en = 1'b1;
    repeat (6) @(negedge clk);
    chk("rst taken", 16'h0, 16'(irq));
    $display("t_reset done");
  endtask
  task automatic t_prio();
    lat = 2'h0;
    @(negedge clk);
    {tmr, host} = 2'b11;
    dma.ch[5] = 1'b1;
    @(negedge clk);
    clr();
    chk("masked irq", 16'h0, 16'(irq));
    chk("masked flags", 16'h2208, flags);
    clr_we = 1'b1;
    clr_d = 16'h0200;
    @(negedge clk);
    clr();
    chk("cleared", 16'h2008, flags);
    mask_we = 1'b1;
    mask_wd = 16'hffff;
    expect_irq(7'h4c, 5'h06, 16'h2008, 1'b0);
    chk("mask", 16'h3efb, mask);
    expect_irq(7'h74, 5'h10, 16'h2000, 1'b1);
    @(negedge clk);
    gen = 1'b0;
    dma.ch[4] = 1'b1;
    @(negedge clk);
    clr();
    chk("disabled irq", 16'h0, 16'(irq));
    chk("disabled flags", 16'h1000, flags);
    gen = 1'b1;
    expect_irq(7'h70, 5'h0f, 16'h1000, 1'b1);
    $display("t_prio done");
  endtask
  task automatic t_traps();
    for (int n = 16; n <= 31; n++) begin
      @(negedge clk);
      trap = 1'b1;
      trap_n = 5'(n);
      if (n == 16 || n == 31) begin
        @(negedge clk);
        clr();
        chk("bad trap", 16'h0, 16'(irq));
      end else begin
        expect_irq(7'(8 + 4 * (n - 17)), 5'h00, 16'h0, 1'b1);
      end
    end
    $display("t_traps done");
  endtask
  task automatic t_table();
    logic [6:0] vt [19] = '{7'h40, 7'h44, 7'h4c, 7'h50, 7'h54, 7'h58, 7'h5c, 7'h64, 7'h68, 7'h6c,
                            7'h58, 7'h5c, 7'h68, 7'h6c, 7'h70, 7'h74, 7'h04, 7'h00, 7'h00};
    logic [4:0] pt [19] = '{5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e,
                            5'h09, 5'h0a, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h02, 5'h01, 5'h01};
    int         bt [19] = '{0, 1, 3, 4, 5, 6, 7, 9, 10, 11, 6, 7, 10, 11, 12, 13, 16, 16, 16};
    for (int k = 0; k < 19; k++) begin
      @(negedge clk);
      drive(k);
      expect_irq(vt[k], pt[k], 16'(17'h1 << bt[k]), 1'b1);
    end
    $display("t_table done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clr();
    {gen, en, lat, sel, trap_n, mask_wd, clr_d} = {1'b1, 1'b0, 2'h2, 4'h0, 5'h00, 16'h0000, 16'h0000};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_prio();
    t_traps();
    t_table();
    report_and_stop();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
endmodule
bind ivpm_top ivpm_checker u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reset_request_i(reset_request_i),
  .soft_reset_i(soft_reset_i), .watchdog_request_i(watchdog_request_i), .timer_request_i(timer_request_i),
  .host_to_core_bit_i(host_to_core_bit_i), .mask_we_i(mask_we_i), .mask_wdata_i(mask_wdata_i),
  .global_enable_i(global_enable_i), .ack_i(ack_i), .irq_o(irq_o), .vector_o(vector_o),
  .priority_o(priority_o), .pending_flags_o(pending_flags_o), .enable_mask_o(enable_mask_o));
`default_nettype wire
